// file: rtl/iso_irq_defines.svh
`ifndef ISO_IRQ_DEFINES_SVH
`define ISO_IRQ_DEFINES_SVH

// Register byte offsets
`define ISO_TX_EVENT_SET_OFS    8'h90
`define ISO_TX_EVENT_CLEAR_OFS  8'h94
`define ISO_TX_MASK_SET_OFS     8'h98
`define ISO_TX_MASK_CLEAR_OFS   8'h9c
`define ISO_RX_EVENT_SET_OFS    8'ha0
`define ISO_RX_EVENT_CLEAR_OFS  8'ha4
`define ISO_RX_MASK_SET_OFS     8'ha8
`define ISO_RX_MASK_CLEAR_OFS   8'hac
`define MAIN_MASK_SET_OFS       8'hc0
`define MAIN_MASK_CLEAR_OFS     8'hc4
`define SUMMARY_STATUS_OFS      8'hc8

// Field widths and positions
`define TX_CTX_COUNT            8
`define RX_CHAN_COUNT           4
`define MAIN_REQ_SEND_BIT       0
`define MAIN_ISO_SEND_BIT       6
`define MAIN_ISO_RECEIVE_BIT    7
`define MAIN_GLOBAL_EN_BIT      31

// Reset values
`define TX_EVENT_RESET          8'h00
`define TX_MASK_RESET           8'h00
`define RX_EVENT_RESET          4'h0
`define RX_MASK_RESET           4'h0

`endif

// file: rtl/iso_irq_pkg.sv
package iso_irq_pkg;

    typedef struct packed {
        logic global_irq_enable;
        logic iso_receive_en;
        logic iso_send_en;
        logic request_send_done_en;
    } main_mask_t;

    typedef struct packed {
        logic [7:0]  tx_event;
        logic [7:0]  tx_mask;
        logic [3:0]  rx_event;
        logic [3:0]  rx_mask;
        logic [7:0]  tx_irq_prev;
        logic [3:0]  rx_irq_prev;
        main_mask_t  main_mask;
        logic [31:0] rdata;
        logic        slverr;
    } state_t;

    typedef struct packed {
        logic iso_send_summary;
        logic iso_receive_summary;
        logic request_send_done_irq;
        logic irq;
    } irq_out_t;

endpackage : iso_irq_pkg

// file: rtl/iso_context_interrupt_regs.sv
// Behaviour
// - Request-done irq needs mask0 and event0 set
// - Send context completion raises its event
// - Receive context completion raises its event
// - Event bit sets on rising edge or set-write
// - Only clear-write of one clears event bit
// - Send clear read returns event AND mask
// - Receive clear read returns event AND mask
// - Send bits 7..0 flag send summary
// - Send event bits 31..8 read zero
// - Receive bits 3..0 flag receive summary
// - Receive event bits 31..4 read zero
// - Send mask via set and clear addresses
// - Send mask bit aligns with event bit
// - Receive mask via set and clear addresses
// - Receive mask bit aligns with event bit
// - Mask reads at either address return mask
// - Receive mask resets to zero
// - Send event upper bits read zero after reset
// - No combined irq without global enable
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "iso_irq_defines.svh"

module iso_context_interrupt_regs (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Context completion signals from the DMA engines
    input  wire logic [7:0]              tx_ctx_irq,
    input  wire logic [3:0]              rx_ctx_irq,
    // Main event register bit 0
    input  wire logic                    request_send_done,
    // Interrupt outputs
    output iso_irq_pkg::irq_out_t        irq_out
);

    iso_irq_pkg::state_t s_q;
    iso_irq_pkg::state_t s_d;

    // Bus phase qualifiers
    logic        wr_access;
    logic        rd_setup;

    // Offset hits, shared by the read and write decoders
    logic        hit_tx_event_set;
    logic        hit_tx_event_clear;
    logic        hit_tx_mask_set;
    logic        hit_tx_mask_clear;
    logic        hit_rx_event_set;
    logic        hit_rx_event_clear;
    logic        hit_rx_mask_set;
    logic        hit_rx_mask_clear;
    logic        hit_main_mask_set;
    logic        hit_main_mask_clear;
    logic        hit_summary;
    logic        hit_any;

    // Write strobes, one per writable offset
    logic        wr_tx_event_set;
    logic        wr_tx_event_clear;
    logic        wr_tx_mask_set;
    logic        wr_tx_mask_clear;
    logic        wr_rx_event_set;
    logic        wr_rx_event_clear;
    logic        wr_rx_mask_set;
    logic        wr_rx_mask_clear;
    logic        wr_main_mask_set;
    logic        wr_main_mask_clear;

    // Byte-lane filtered write data
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [7:0]  tx_wbits;
    logic [3:0]  rx_wbits;
    logic [3:0]  main_wbits;

    // Completion edges from the DMA contexts
    logic [7:0]  tx_rise;
    logic [3:0]  rx_rise;

    // Ones to set and ones to clear, per field
    logic [7:0]  tx_event_set_bits;
    logic [7:0]  tx_event_clear_bits;
    logic [7:0]  tx_mask_set_bits;
    logic [7:0]  tx_mask_clear_bits;
    logic [3:0]  rx_event_set_bits;
    logic [3:0]  rx_event_clear_bits;
    logic [3:0]  rx_mask_set_bits;
    logic [3:0]  rx_mask_clear_bits;
    logic [3:0]  main_set_bits;
    logic [3:0]  main_clear_bits;

    // Next values of the event and mask fields
    logic [7:0]  tx_event_nxt;
    logic [7:0]  tx_mask_nxt;
    logic [3:0]  rx_event_nxt;
    logic [3:0]  rx_mask_nxt;
    logic [3:0]  main_mask_nxt;

    // Pending sources and summaries
    logic [7:0]  tx_pending;
    logic [3:0]  rx_pending;
    logic        send_summary;
    logic        receive_summary;
    logic        req_irq;
    logic        send_irq;
    logic        receive_irq;
    logic        any_source;

    // Read path
    logic [31:0] tx_event_view;
    logic [31:0] tx_pending_view;
    logic [31:0] tx_mask_view;
    logic [31:0] rx_event_view;
    logic [31:0] rx_pending_view;
    logic [31:0] rx_mask_view;
    logic [31:0] main_view;
    logic [31:0] summary_view;
    logic [31:0] rd_word;
    logic        rd_err;

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign prdata  = s_q.rdata;
    assign pslverr = s_q.slverr;

    assign wr_access = psel & penable & pwrite;
    assign rd_setup  = psel & ~penable;

    assign hit_tx_event_set    = (paddr == `ISO_TX_EVENT_SET_OFS);
    assign hit_tx_event_clear  = (paddr == `ISO_TX_EVENT_CLEAR_OFS);
    assign hit_tx_mask_set     = (paddr == `ISO_TX_MASK_SET_OFS);
    assign hit_tx_mask_clear   = (paddr == `ISO_TX_MASK_CLEAR_OFS);
    assign hit_rx_event_set    = (paddr == `ISO_RX_EVENT_SET_OFS);
    assign hit_rx_event_clear  = (paddr == `ISO_RX_EVENT_CLEAR_OFS);
    assign hit_rx_mask_set     = (paddr == `ISO_RX_MASK_SET_OFS);
    assign hit_rx_mask_clear   = (paddr == `ISO_RX_MASK_CLEAR_OFS);
    assign hit_main_mask_set   = (paddr == `MAIN_MASK_SET_OFS);
    assign hit_main_mask_clear = (paddr == `MAIN_MASK_CLEAR_OFS);
    assign hit_summary         = (paddr == `SUMMARY_STATUS_OFS);
    assign hit_any             = hit_tx_event_set | hit_tx_event_clear | hit_tx_mask_set | hit_tx_mask_clear
                                 | hit_rx_event_set | hit_rx_event_clear | hit_rx_mask_set | hit_rx_mask_clear
                                 | hit_main_mask_set | hit_main_mask_clear | hit_summary;

    // Writes to the summary offset and to unmapped offsets change nothing
    assign wr_tx_event_set    = wr_access & hit_tx_event_set;
    assign wr_tx_event_clear  = wr_access & hit_tx_event_clear;
    assign wr_tx_mask_set     = wr_access & hit_tx_mask_set;
    assign wr_tx_mask_clear   = wr_access & hit_tx_mask_clear;
    assign wr_rx_event_set    = wr_access & hit_rx_event_set;
    assign wr_rx_event_clear  = wr_access & hit_rx_event_clear;
    assign wr_rx_mask_set     = wr_access & hit_rx_mask_set;
    assign wr_rx_mask_clear   = wr_access & hit_rx_mask_clear;
    assign wr_main_mask_set   = wr_access & hit_main_mask_set;
    assign wr_main_mask_clear = wr_access & hit_main_mask_clear;

    // Byte enables select which written ones count
    assign wmask      = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wbits      = pwdata & wmask;
    assign tx_wbits   = wbits[7:0];
    assign rx_wbits   = wbits[3:0];
    assign main_wbits = {wbits[`MAIN_GLOBAL_EN_BIT], wbits[`MAIN_ISO_RECEIVE_BIT],
                         wbits[`MAIN_ISO_SEND_BIT], wbits[`MAIN_REQ_SEND_BIT]};

    assign tx_rise = tx_ctx_irq & ~s_q.tx_irq_prev;
    assign rx_rise = rx_ctx_irq & ~s_q.rx_irq_prev;

    // Hardware edges join the set-writes; a set in the same cycle beats a clear
    assign tx_event_set_bits   = tx_rise | (wr_tx_event_set ? tx_wbits : 8'h00);
    assign tx_event_clear_bits = wr_tx_event_clear ? tx_wbits : 8'h00;
    assign tx_mask_set_bits    = wr_tx_mask_set ? tx_wbits : 8'h00;
    assign tx_mask_clear_bits  = wr_tx_mask_clear ? tx_wbits : 8'h00;
    assign rx_event_set_bits   = rx_rise | (wr_rx_event_set ? rx_wbits : 4'h0);
    assign rx_event_clear_bits = wr_rx_event_clear ? rx_wbits : 4'h0;
    assign rx_mask_set_bits    = wr_rx_mask_set ? rx_wbits : 4'h0;
    assign rx_mask_clear_bits  = wr_rx_mask_clear ? rx_wbits : 4'h0;
    assign main_set_bits       = wr_main_mask_set ? main_wbits : 4'h0;
    assign main_clear_bits     = wr_main_mask_clear ? main_wbits : 4'h0;

    assign tx_pending = s_q.tx_event & s_q.tx_mask;
    assign rx_pending = s_q.rx_event & s_q.rx_mask;

    // Send event bits
    set_clear_vec #(
        .WIDTH (`TX_CTX_COUNT)
    ) u_tx_event (
        .cur        (s_q.tx_event),
        .set_bits   (tx_event_set_bits),
        .clear_bits (tx_event_clear_bits),
        .nxt        (tx_event_nxt)
    );

    // Send mask bits
    set_clear_vec #(
        .WIDTH (`TX_CTX_COUNT)
    ) u_tx_mask (
        .cur        (s_q.tx_mask),
        .set_bits   (tx_mask_set_bits),
        .clear_bits (tx_mask_clear_bits),
        .nxt        (tx_mask_nxt)
    );

    // Receive event bits
    set_clear_vec #(
        .WIDTH (`RX_CHAN_COUNT)
    ) u_rx_event (
        .cur        (s_q.rx_event),
        .set_bits   (rx_event_set_bits),
        .clear_bits (rx_event_clear_bits),
        .nxt        (rx_event_nxt)
    );

    // Receive mask bits
    set_clear_vec #(
        .WIDTH (`RX_CHAN_COUNT)
    ) u_rx_mask (
        .cur        (s_q.rx_mask),
        .set_bits   (rx_mask_set_bits),
        .clear_bits (rx_mask_clear_bits),
        .nxt        (rx_mask_nxt)
    );

    // Main mask bits, in the order of the packed struct
    set_clear_vec #(
        .WIDTH (4)
    ) u_main_mask (
        .cur        (s_q.main_mask),
        .set_bits   (main_set_bits),
        .clear_bits (main_clear_bits),
        .nxt        (main_mask_nxt)
    );

    assign send_summary    = |tx_pending;
    assign receive_summary = |rx_pending;
    assign req_irq         = s_q.main_mask.request_send_done_en & request_send_done;
    assign send_irq        = send_summary & s_q.main_mask.iso_send_en;
    assign receive_irq     = receive_summary & s_q.main_mask.iso_receive_en;
    assign any_source      = req_irq | send_irq | receive_irq;

    // Reserved bits above each field read zero
    assign tx_event_view   = {24'h00_0000, s_q.tx_event};
    assign tx_pending_view = {24'h00_0000, tx_pending};
    assign tx_mask_view    = {24'h00_0000, s_q.tx_mask};
    assign rx_event_view   = {28'h000_0000, s_q.rx_event};
    assign rx_pending_view = {28'h000_0000, rx_pending};
    assign rx_mask_view    = {28'h000_0000, s_q.rx_mask};

    // Main mask and summary words, each bit at its register position
    always_comb begin
        main_view                           = 32'h0000_0000;
        main_view[`MAIN_GLOBAL_EN_BIT]      = s_q.main_mask.global_irq_enable;
        main_view[`MAIN_ISO_RECEIVE_BIT]    = s_q.main_mask.iso_receive_en;
        main_view[`MAIN_ISO_SEND_BIT]       = s_q.main_mask.iso_send_en;
        main_view[`MAIN_REQ_SEND_BIT]       = s_q.main_mask.request_send_done_en;
        summary_view                        = 32'h0000_0000;
        summary_view[`MAIN_ISO_RECEIVE_BIT] = receive_summary;
        summary_view[`MAIN_ISO_SEND_BIT]    = send_summary;
        summary_view[`MAIN_REQ_SEND_BIT]    = req_irq;
    end

    // Word shown for a read whose setup is this cycle; unmapped offsets are refused
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err  = ~hit_any;
        case (paddr)
            `ISO_TX_EVENT_SET_OFS: begin
                rd_word = tx_event_view;
            end
            `ISO_TX_EVENT_CLEAR_OFS: begin
                rd_word = tx_pending_view;
            end
            `ISO_TX_MASK_SET_OFS: begin
                rd_word = tx_mask_view;
            end
            `ISO_TX_MASK_CLEAR_OFS: begin
                rd_word = tx_mask_view;
            end
            `ISO_RX_EVENT_SET_OFS: begin
                rd_word = rx_event_view;
            end
            `ISO_RX_EVENT_CLEAR_OFS: begin
                rd_word = rx_pending_view;
            end
            `ISO_RX_MASK_SET_OFS: begin
                rd_word = rx_mask_view;
            end
            `ISO_RX_MASK_CLEAR_OFS: begin
                rd_word = rx_mask_view;
            end
            `MAIN_MASK_SET_OFS: begin
                rd_word = main_view;
            end
            `MAIN_MASK_CLEAR_OFS: begin
                rd_word = main_view;
            end
            `SUMMARY_STATUS_OFS: begin
                rd_word = summary_view;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        s_d             = s_q;
        s_d.tx_irq_prev = tx_ctx_irq;
        s_d.rx_irq_prev = rx_ctx_irq;
        s_d.tx_event    = tx_event_nxt;
        s_d.rx_event    = rx_event_nxt;
        s_d.tx_mask     = tx_mask_nxt;
        s_d.rx_mask     = rx_mask_nxt;
        s_d.main_mask   = main_mask_nxt;

        // Read data is captured in the setup cycle and shown in the access cycle
        if (rd_setup) begin
            s_d.rdata  = rd_word;
            s_d.slverr = rd_err;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q             <= '0;
            s_q.tx_event    <= `TX_EVENT_RESET;
            s_q.tx_mask     <= `TX_MASK_RESET;
            s_q.rx_event    <= `RX_EVENT_RESET;
            s_q.rx_mask     <= `RX_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        irq_out.iso_send_summary      = send_summary;
        irq_out.iso_receive_summary   = receive_summary;
        irq_out.request_send_done_irq = req_irq;
        irq_out.irq                   = s_q.main_mask.global_irq_enable & any_source;
    end

endmodule : iso_context_interrupt_regs

// Next value of a field written through paired set and clear offsets
module set_clear_vec #(
    parameter int WIDTH = 8
) (
    // Present value
    input  wire logic [WIDTH-1:0] cur,
    // Ones to set and ones to clear
    input  wire logic [WIDTH-1:0] set_bits,
    input  wire logic [WIDTH-1:0] clear_bits,
    // Next value
    output logic [WIDTH-1:0]      nxt
);

    // Clear is applied first so that a set in the same cycle wins
    assign nxt = (cur & ~clear_bits) | set_bits;

endmodule : set_clear_vec

// file: verification/iso_irq_props.sv
`timescale 1ns/1ns
module iso_irq_props (
    input wire logic                  core_clk, srst, psel, penable, pwrite, pready, pslverr,
    input wire logic                  request_send_done,
    input wire logic [7:0]            paddr, tx_ctx_irq,
    input wire logic [31:0]           pwdata, prdata,
    input wire logic [3:0]            pstrb, rx_ctx_irq,
    input wire iso_irq_pkg::irq_out_t irq_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic [7:0] tx_q;
    logic       wr, mapped, tx_cause;
    assign wr = psel && penable && pwrite;
    assign mapped = paddr inside {[8'h90:8'hac], [8'hc0:8'hc8]} && paddr[1:0] == 2'h0;
    assign tx_cause = |(tx_ctx_irq & ~tx_q) || (wr && paddr inside {8'h90, 8'h98});
    always_ff @(posedge core_clk) tx_q <= srst ? 8'h00 : tx_ctx_irq;
    // Read setup followed by its access cycle
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence
    a_ready_high: assert property (psel && penable |-> pready) else $error("pready low");
    a_tx_rsvd_zero: assert property (s_rd(8'h94) |-> prdata[31:8] == 24'h00_0000)
        else $error("send reserved bits set");
    a_rx_rsvd_zero: assert property (s_rd(8'ha4) |-> prdata[31:4] == 28'h000_0000)
        else $error("receive reserved bits set");
    a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_req_irq_cause: assert property (irq_out.request_send_done_irq |-> request_send_done)
        else $error("request irq without event");
    a_irq_has_cause: assert property (irq_out.irq |-> irq_out.request_send_done_irq
        || irq_out.iso_send_summary || irq_out.iso_receive_summary) else $error("irq without source");
    a_tx_sum_holds: assert property (irq_out.iso_send_summary && !(wr && paddr inside {8'h94, 8'h9c})
        |=> irq_out.iso_send_summary) else $error("send summary dropped");
    a_rx_sum_holds: assert property (irq_out.iso_receive_summary && !(wr && paddr inside {8'ha4, 8'hac})
        |=> irq_out.iso_receive_summary) else $error("receive summary dropped");
    a_tx_rise_cause: assert property ($rose(irq_out.iso_send_summary) |-> $past(tx_cause))
        else $error("send summary rose without cause");
endmodule : iso_irq_props

bind iso_context_interrupt_regs iso_irq_props u_props (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .request_send_done(request_send_done), .tx_ctx_irq(tx_ctx_irq), .pwdata(pwdata), .prdata(prdata),
    .pstrb(pstrb), .rx_ctx_irq(rx_ctx_irq), .irq_out(irq_out));

// file: verification/tb_iso_context_interrupt_regs.sv
`timescale 1ns/1ns
module tb_iso_context_interrupt_regs;
    logic                  core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, request_send_done = 0;
    logic                  pready, pslverr, err_q;
    logic [7:0]            paddr = 0, tx_ctx_irq = 0;
    logic [31:0]           pwdata = 0, prdata, rd_q;
    logic [3:0]            pstrb = 4'hf, rx_ctx_irq = 0;
    iso_irq_pkg::irq_out_t irq_out;
    int                    bad_count = 0, compares = 0, cyc = 0;
    iso_context_interrupt_regs u_dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tx_ctx_irq(tx_ctx_irq), .rx_ctx_irq(rx_ctx_irq),
        .request_send_done(request_send_done), .irq_out(irq_out));
    initial forever #10 core_clk = ~core_clk;
    task automatic wrap_up;
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One APB transfer, then one idle cycle
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 0; penable <= 0;
        @(posedge core_clk);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 0, 0);
        chk($sformatf("reg %h", a), rd_q, exp);
    endtask : rd
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 0;
        @(posedge core_clk);
        for (int a = 'h90; a <= 'hac; a += 4) rd(8'(a), 0);
        chk("irq_out", 32'(irq_out), 0);
        xfer(8'h98, 1, 32'hffff_ffff);
        rd(8'h9c, 32'h0000_00ff);
        xfer(8'h9c, 1, 32'h0000_000f);
        rd(8'h98, 32'h0000_00f0);
        xfer(8'ha8, 1, 32'hffff_ffff);
        xfer(8'hac, 1, 32'h0000_0005);
        rd(8'hac, 32'h0000_000a);
        tx_ctx_irq <= 8'h81;
        rx_ctx_irq <= 4'hf;
        @(posedge core_clk);
        rd(8'h90, 32'h0000_0081);
        rd(8'h94, 32'h0000_0080);
        rd(8'ha0, 32'h0000_000f);
        rd(8'ha4, 32'h0000_000a);
        chk("summaries", 32'({irq_out.iso_send_summary, irq_out.iso_receive_summary}), 3);
        xfer(8'h94, 1, 32'h0000_0001);
        xfer(8'h94, 1, 32'h0000_0000);
        rd(8'h90, 32'h0000_0080);
        xfer(8'h90, 1, 32'hffff_ff02);
        rd(8'h90, 32'h0000_0082);
        pstrb <= 4'he;
        xfer(8'h90, 1, 32'h0000_0004);
        pstrb <= 4'hf;
        rd(8'h90, 32'h0000_0082);
        request_send_done <= 1;
        xfer(8'hc0, 1, 32'h0000_0001);
        chk("request irq", 32'({irq_out.request_send_done_irq, irq_out.irq}), 2);
        xfer(8'hc0, 1, 32'h8000_0000);
        chk("irq", 32'(irq_out.irq), 1);
        xfer(8'hc4, 1, 32'h0000_0001);
        chk("irq", 32'(irq_out.irq), 0);
        xfer(8'hc0, 1, 32'h0000_0040);
        chk("irq", 32'(irq_out.irq), 1);
        rd(8'hc8, 32'h0000_00c0);
        rd(8'hc4, 32'h8000_0040);
        xfer(8'h94, 1, 32'h0000_00ff);
        xfer(8'ha4, 1, 32'h0000_000f);
        chk("irq_out", 32'(irq_out), 0);
        xfer(8'h10, 0, 0);
        chk("pslverr", 32'(err_q), 1);
        chk("prdata", rd_q, 0);
        xfer(8'h14, 1, 32'hffff_ffff);
        chk("pslverr wr", 32'(err_q), 1);
        xfer(8'h90, 1, 32'h0000_0011);
        xfer(8'ha8, 1, 32'h0000_0003);
        srst <= 1;
        tx_ctx_irq <= 0;
        rx_ctx_irq <= 0;
        @(posedge core_clk);
        srst <= 0;
        @(posedge core_clk);
        rd(8'h90, 0);
        rd(8'ha8, 0);
        rd(8'hc0, 0);
        chk("irq_out", 32'(irq_out), 0);
        wrap_up();
    end
endmodule : tb_iso_context_interrupt_regs
